/* core/ifat_pkg.sv */
// shared constants and carrier types for the instruction decode and timing block
package ifat_pkg;
    localparam int unsigned IFAT_WORD_W = 14;
    localparam int unsigned IFAT_FILE_W = 7;
    localparam int unsigned IFAT_DATA_W = 8;
    localparam int unsigned IFAT_OSC_PER_ICYC = 4;
    localparam logic [1:0] IFAT_PHASE_LAST = 2'h3;
    localparam logic [6:0] IFAT_INDF0_ADDR = 7'h00;
    localparam logic [6:0] IFAT_INDF1_ADDR = 7'h01;
    localparam int unsigned IFAT_BIT_LSB = 7;
    localparam int unsigned IFAT_DEST_POS = 7;
    localparam int unsigned IFAT_PTR_POS = 6;
    localparam int unsigned IFAT_MODE_LSB = 0;
    localparam logic [4:0] IFAT_RF_DEPTH = 5'h10;
    localparam logic [7:0] IFAT_REG_RESET = 8'h00;

    typedef enum logic [3:0] {
        IFAT_ST_FETCH  = 4'h1,
        IFAT_ST_EXEC   = 4'h2,
        IFAT_ST_SECOND = 4'h4,
        IFAT_ST_THIRD  = 4'h8
    } ifat_state_e;

    typedef struct packed {
        logic [5:0] opcode;
        logic dest_file;
        logic [6:0] file_addr;
        logic [2:0] bit_sel;
        logic [7:0] lit8;
        logic [10:0] lit11;
        logic [8:0] lit9;
        logic [6:0] lit7;
        logic [4:0] lit5;
        logic [5:0] lit6;
        logic ptr_sel;
        logic [1:0] ptr_mode;
    } ifat_fields_s;

    typedef struct packed {
        logic [1:0] cycles;
        logic two_cycle;
        logic is_file_op;
        logic is_bit_skip;
        logic is_indirect;
        logic is_ptr_move;
    } ifat_class_s;
endpackage

/* core/ifat_file_mem.sv */
// small file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ifat_file_mem import ifat_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [6:0] i_raddr,
    input wire logic i_we,
    input wire logic [6:0] i_waddr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:127];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= IFAT_REG_RESET;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule // ifat_file_mem
`default_nettype wire

/* core/ifat_core.sv */
// instruction field decode, cycle timing and read-modify-write sequencing
// What this block does
// [RULE1] every instruction is one 14-bit word holding opcode and operands
// [RULE2] instructions take one instruction cycle unless listed below
// [RULE3] literal call and call via working register take two cycles
// [RULE4] return, return with literal and return from interrupt take two cycles
// [RULE5] jumps, relative branches, bit skips and count skips take two cycles
// [RULE6] indirect access with pointer in program memory adds one cycle
// [RULE7] one instruction cycle is four oscillator clocks
// [RULE8] writes to a named file register read, modify, then store
// [RULE9] the addressed register is always read, even for pure writes
// [RULE10] destination bit 0 stores to working register, 1 to file register
// [RULE11] byte operations carry 7-bit file address and destination bit
// [RULE12] bit operations carry 3-bit bit index and 7-bit file address
// [RULE13] literal and control operations carry 8-bit immediate in low bits
// [RULE14] call and jump carry 11-bit immediate target
// [RULE15] formats with 9-bit and 7-bit immediates are decoded
// [RULE16] a format with a 5-bit immediate is decoded
// [RULE17] pointer arithmetic pairs pointer select with 6-bit immediate
// [RULE18] pointer select chooses pointer or indirect port 0 or 1
// [RULE19] indirect move carries 2-bit pre/post increment/decrement mode
// [RULE20] don't-care bits are ignored, either value accepted
// [RULE21] bit skip second cycle discards the fetched word as a no-op
`timescale 1ns/1ps
`default_nettype none
module ifat_core import ifat_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [13:0] i_instr,
    input wire logic i_ptr0_in_prog,
    input wire logic i_ptr1_in_prog,
    output logic o_fetch,
    output logic o_icyc_end,
    output logic [1:0] o_phase,
    output logic [13:0] o_ir,
    output ifat_fields_s o_fields,
    output ifat_class_s o_class,
    output logic o_wreg_we,
    output logic [7:0] o_wreg,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    output logic o_skip_taken,
    output logic o_busy
);
    typedef struct packed {
        ifat_state_e state;
        logic [1:0] phase;
        logic [13:0] ir;
        ifat_fields_s fields;
        ifat_class_s cls;
        logic [1:0] left;
        logic fetch;
        logic icyc_end;
        logic wreg_we;
        logic [7:0] wreg;
        logic file_we;
        logic [6:0] file_addr;
        logic [7:0] file_wdata;
        logic skip_pending;
        logic skip_taken;
    } ifat_core_s;

    ifat_core_s cur;
    ifat_core_s next_cur;
    logic [7:0] rd_data;
    ifat_fields_s dec_f;
    ifat_class_s dec_c;
    logic [7:0] alu_res;
    logic alu_skip;

    ifat_file_mem u_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_raddr(dec_f.file_addr),
        .i_we(cur.file_we),
        .i_waddr(cur.file_addr),
        .i_wdata(cur.file_wdata),
        .o_rdata(rd_data)
    );

    // every field is sliced in parallel; the class decode picks which one matters
    always_comb begin
        dec_f.opcode = cur.ir[13:8];
        dec_f.dest_file = cur.ir[IFAT_DEST_POS]; // [RULE10] [RULE11]
        dec_f.file_addr = cur.ir[6:0]; // [RULE11] [RULE12]
        dec_f.bit_sel = cur.ir[IFAT_BIT_LSB +: 3]; // [RULE12]
        dec_f.lit8 = cur.ir[7:0]; // [RULE13]
        dec_f.lit11 = cur.ir[10:0]; // [RULE14]
        dec_f.lit9 = cur.ir[8:0]; // [RULE15]
        dec_f.lit7 = cur.ir[6:0]; // [RULE15]
        dec_f.lit5 = cur.ir[4:0]; // [RULE16]
        dec_f.lit6 = cur.ir[5:0]; // [RULE17]
        dec_f.ptr_sel = cur.ir[IFAT_PTR_POS]; // [RULE18]
        dec_f.ptr_mode = cur.ir[IFAT_MODE_LSB +: 2]; // [RULE19]
    end

    // opcode classes; the fixed control words (call or branch via working register, return, return from interrupt) are compared on all 14 bits
    always_comb begin
        logic call_lit;
        logic jump;
        logic call_w;
        logic ret;
        logic relative_branch_literal;
        logic relative_branch_working;
        logic retfi;
        logic retlit;
        logic bskip;
        logic cskip;
        logic indir;
        call_lit = cur.ir[13:11] == 3'h4;
        jump = cur.ir[13:11] == 3'h5;
        relative_branch_literal = cur.ir[13:9] == 5'h19;
        retlit = cur.ir[13:8] == 6'h34;
        bskip = cur.ir[13:11] == 3'h3; // bit skips, both polarities
        cskip = (cur.ir[13:8] == 6'h0b) || (cur.ir[13:8] == 6'h0f);
        call_w = cur.ir == 14'h000a;
        relative_branch_working = cur.ir == 14'h000b;
        ret = cur.ir == 14'h0008;
        retfi = cur.ir == 14'h0009;
        // opcode 0 with the destination bit set is the store of the working register
        indir = (cur.ir[13:12] == 2'h0) && ((cur.ir[13:8] != 6'h00) || cur.ir[IFAT_DEST_POS])
                && (cur.ir[6:1] == 6'h00);
        dec_c.is_bit_skip = bskip;
        dec_c.is_file_op = (cur.ir[13:12] == 2'h0)
                           && ((cur.ir[13:8] != 6'h00) || cur.ir[IFAT_DEST_POS]); // [RULE8]
        dec_c.is_indirect = indir && ((cur.ir[0] ? i_ptr1_in_prog : i_ptr0_in_prog));
        dec_c.is_ptr_move = cur.ir[13:3] == 11'h002; // [RULE19]
        dec_c.two_cycle = call_lit || call_w // [RULE3]
                          || ret || retlit || retfi // [RULE4]
                          || jump || relative_branch_literal || relative_branch_working || bskip || cskip; // [RULE5]
        dec_c.cycles = 2'h1 + {1'h0, dec_c.two_cycle}
                       + {1'h0, dec_c.is_indirect}; // [RULE2] [RULE6]
    end

    // modify step for byte and bit operations on the operand just read
    always_comb begin
        alu_res = rd_data;
        alu_skip = 1'b0;
        case (cur.ir[13:8])
            6'h0b: begin
                alu_res = rd_data - 8'h01;
                alu_skip = alu_res == 8'h00; // [RULE5]
            end
            6'h0f: begin
                alu_res = rd_data + 8'h01;
                alu_skip = alu_res == 8'h00; // [RULE5]
            end
            6'h0a: alu_res = rd_data + 8'h01;
            6'h03: alu_res = rd_data - 8'h01;
            6'h09: alu_res = ~rd_data;
            6'h01: alu_res = 8'h00; // pure write still read first [RULE9]
            6'h00: alu_res = cur.wreg;
            default: alu_res = rd_data;
        endcase
        if (cur.ir[13:11] == 3'h3) begin
            alu_skip = rd_data[cur.ir[IFAT_BIT_LSB +: 3]] == cur.ir[10]; // [RULE12]
        end
    end

    always_comb begin
        next_cur = cur;
        next_cur.phase = cur.phase + 2'h1; // four clocks per instruction cycle [RULE7]
        next_cur.icyc_end = cur.phase == (IFAT_PHASE_LAST - 2'h1);
        next_cur.fetch = 1'b0;
        next_cur.wreg_we = 1'b0;
        next_cur.file_we = 1'b0;
        next_cur.skip_taken = 1'b0;
        if (cur.phase == IFAT_PHASE_LAST) begin
            case (cur.state)
                IFAT_ST_FETCH: begin
                    next_cur.ir = i_instr; // one whole word per instruction [RULE1]
                    next_cur.fetch = 1'b1;
                    next_cur.state = IFAT_ST_EXEC;
                end
                IFAT_ST_EXEC: begin
                    next_cur.fields = dec_f;
                    next_cur.cls = dec_c;
                    next_cur.left = dec_c.cycles - 2'h1;
                    if (dec_c.is_file_op && !dec_c.is_bit_skip) begin
                        // read at the last phase, store now [RULE8]
                        if (dec_f.dest_file) begin
                            next_cur.file_we = 1'b1; // [RULE10]
                            next_cur.file_addr = dec_f.file_addr;
                            next_cur.file_wdata = alu_res;
                        end else begin
                            next_cur.wreg_we = 1'b1; // [RULE10]
                            next_cur.wreg = alu_res;
                        end
                    end else if (cur.ir[13:12] == 2'h3) begin
                        next_cur.wreg_we = 1'b1; // literal to working register [RULE13]
                        next_cur.wreg = dec_f.lit8;
                    end
                    next_cur.skip_pending = alu_skip && (dec_c.is_bit_skip
                                            || cur.ir[13:8] == 6'h0b || cur.ir[13:8] == 6'h0f);
                    if (dec_c.cycles == 2'h1) begin
                        next_cur.state = IFAT_ST_FETCH; // [RULE2]
                    end else begin
                        next_cur.state = IFAT_ST_SECOND;
                    end
                end
                IFAT_ST_SECOND: begin
                    // fetched word is thrown away as a no-op [RULE21]
                    next_cur.skip_taken = cur.skip_pending;
                    next_cur.skip_pending = 1'b0;
                    next_cur.left = cur.left - 2'h1;
                    next_cur.state = (cur.left == 2'h2) ? IFAT_ST_THIRD : IFAT_ST_FETCH; // [RULE6]
                end
                IFAT_ST_THIRD: begin
                    next_cur.left = 2'h0;
                    next_cur.state = IFAT_ST_FETCH; // [RULE6]
                end
                default: next_cur.state = IFAT_ST_FETCH;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '{state: IFAT_ST_FETCH, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fetch <= 1'b0;
            o_icyc_end <= 1'b0;
            o_phase <= 2'h0;
            o_ir <= 14'h0000;
            o_fields <= '0;
            o_class <= '0;
            o_wreg_we <= 1'b0;
            o_wreg <= 8'h00;
            o_file_we <= 1'b0;
            o_file_addr <= 7'h00;
            o_file_wdata <= 8'h00;
            o_skip_taken <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_fetch <= next_cur.fetch;
            o_icyc_end <= next_cur.icyc_end;
            o_phase <= next_cur.phase;
            o_ir <= next_cur.ir;
            o_fields <= next_cur.fields;
            o_class <= next_cur.cls;
            o_wreg_we <= next_cur.wreg_we;
            o_wreg <= next_cur.wreg;
            o_file_we <= next_cur.file_we;
            o_file_addr <= next_cur.file_addr;
            o_file_wdata <= next_cur.file_wdata;
            o_skip_taken <= next_cur.skip_taken;
            o_busy <= (next_cur.state == IFAT_ST_SECOND) || (next_cur.state == IFAT_ST_THIRD);
        end
    end
endmodule // ifat_core
`default_nettype wire

/* test/ifat_core_asserts.sv */
// concurrent checks on the decode and timing ports of ifat_core
`timescale 1ns/1ps
`default_nettype none
module ifat_core_asserts import ifat_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [13:0] i_instr,
    input wire logic i_ptr0_in_prog,
    input wire logic i_ptr1_in_prog,
    input wire logic o_fetch,
    input wire logic o_icyc_end,
    input wire logic [1:0] o_phase,
    input wire logic [13:0] o_ir,
    input wire ifat_fields_s o_fields,
    input wire ifat_class_s o_class,
    input wire logic o_wreg_we,
    input wire logic [7:0] o_wreg,
    input wire logic o_file_we,
    input wire logic [6:0] o_file_addr,
    input wire logic [7:0] o_file_wdata,
    input wire logic o_skip_taken,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    phase_step_a: assert property ((o_phase != 2'h3) |=> (o_phase == $past(o_phase) + 2'h1))
        else $error("phase did not advance");
    phase_wrap_a: assert property ((o_phase == 2'h3) |=> (o_phase == 2'h0))
        else $error("phase did not wrap");
    cycle_end_a: assert property (o_icyc_end == (o_phase == 2'h3))
        else $error("cycle end pulse misplaced");
    fetch_take_a: assert property (o_fetch |-> (o_phase == 2'h0) && (o_ir == $past(i_instr)))
        else $error("fetched word not latched");
    fetch_gap_a: assert property (o_fetch |=> !o_fetch [*7])
        else $error("fetch too soon");
    busy_block_a: assert property (o_busy |-> !o_fetch)
        else $error("fetch while busy");
    busy_len_a: assert property ($rose(o_busy) |-> (o_phase == 2'h0) && o_busy [*4])
        else $error("extra cycle too short");
    busy_class_a: assert property (o_fetch |-> ##4 (o_busy == (o_class.cycles != 2'h1)))
        else $error("busy disagrees with cycle count");
    byte_fields_a: assert property (o_fetch |-> ##4 (o_fields.file_addr == o_ir[6:0] &&
        o_fields.dest_file == o_ir[7] && o_fields.bit_sel == o_ir[9:7] && o_fields.lit11 == o_ir[10:0]))
        else $error("file or bit fields wrong");
    lit_fields_a: assert property (o_fetch |-> ##4 (o_fields.lit8 == o_ir[7:0] && o_fields.lit9 == o_ir[8:0] &&
        o_fields.lit7 == o_ir[6:0] && o_fields.lit5 == o_ir[4:0] && o_fields.lit6 == o_ir[5:0] &&
        o_fields.ptr_sel == o_ir[6] && o_fields.ptr_mode == o_ir[1:0])) else $error("literal fields wrong");
    skip_nop_a: assert property (o_skip_taken |-> !o_wreg_we && !o_file_we)
        else $error("discarded cycle wrote a result");
    // pointer ports 0 and 1 may be redirected, so only direct addresses are tied
    file_addr_a: assert property (o_file_we && o_fields.file_addr > 7'h01 |-> o_file_addr == o_fields.file_addr)
        else $error("write went to wrong file register");
endmodule // ifat_core_asserts
bind ifat_core ifat_core_asserts u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
    .i_ptr0_in_prog(i_ptr0_in_prog), .i_ptr1_in_prog(i_ptr1_in_prog), .o_fetch(o_fetch),
    .o_icyc_end(o_icyc_end), .o_phase(o_phase), .o_ir(o_ir), .o_fields(o_fields), .o_class(o_class),
    .o_wreg_we(o_wreg_we), .o_wreg(o_wreg), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
    .o_file_wdata(o_file_wdata), .o_skip_taken(o_skip_taken), .o_busy(o_busy));
`default_nettype wire

/* test/ifat_prog_mem_model.sv */
// program memory stand-in: presents one loaded word, then no-op words
`timescale 1ns/1ps
`default_nettype none
module ifat_prog_mem_model import ifat_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_fetch,
    input wire logic i_load,
    input wire logic [13:0] i_word,
    output logic [13:0] o_instr
);
    // a taken word is not shown twice, so a stuck fetch shows up as a no-op
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_instr <= 14'h0000;
        else if (i_load) o_instr <= i_word;
        else if (i_fetch) o_instr <= 14'h0000;
    end
endmodule // ifat_prog_mem_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for instruction decode and cycle timing
`timescale 1ns/1ps
`default_nettype none
module tb import ifat_pkg::*;;
    logic i_clk = 1'b0, i_rst_n = 1'b0, p0 = 1'b0, p1 = 1'b0, load = 1'b0;
    logic [13:0] word = 14'h0000;
    logic [13:0] instr, o_ir;
    logic o_fetch, o_icyc_end, o_wreg_we, o_file_we, o_skip_taken, o_busy;
    logic [1:0] o_phase;
    logic [7:0] o_wreg, o_file_wdata;
    logic [6:0] o_file_addr;
    ifat_fields_s o_fields;
    ifat_class_s o_class;
    int fail_count = 0, check_count = 0;
    int skip_seen = 0;
    always #25 i_clk = ~i_clk;
    // counted on the falling edge, away from the edge that launches the pulse
    always @(negedge i_clk) if (o_skip_taken === 1'b1) skip_seen++;
    ifat_prog_mem_model u_mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_fetch(o_fetch), .i_load(load),
        .i_word(word), .o_instr(instr));
    ifat_core u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr(instr), .i_ptr0_in_prog(p0),
        .i_ptr1_in_prog(p1), .o_fetch(o_fetch), .o_icyc_end(o_icyc_end), .o_phase(o_phase), .o_ir(o_ir),
        .o_fields(o_fields), .o_class(o_class), .o_wreg_we(o_wreg_we), .o_wreg(o_wreg),
        .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
        .o_skip_taken(o_skip_taken), .o_busy(o_busy));
    task automatic check(input string name, input logic [79:0] got, input logic [79:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_fetch(output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_fetch !== 1'b1 && n < 64);
    endtask
    // loads one word, then judges latch, spacing, cycle count and fields
    task automatic run_word(input logic [13:0] w, input logic q0, input logic q1, input int cyc);
        int n;
        ifat_fields_s got, e;
        p0 = q0;
        p1 = q1;
        word = w;
        load = 1'b1;
        @(posedge i_clk);
        #1 load = 1'b0;
        wait_fetch(n);
        check("ir", o_ir, w);
        wait_fetch(n);
        check("interval", n, IFAT_OSC_PER_ICYC * (1 + cyc));
        check("cycles", o_class.cycles, cyc);
        e = '{6'h00, w[7], w[6:0], w[9:7], w[7:0], w[10:0], w[8:0], w[6:0], w[4:0], w[5:0], w[6], w[1:0]};
        got = o_fields;
        got.opcode = 6'h00;
        check("fields", got, e);
    endtask
    // one word through the file path, then judges working register, stored data and skips
    task automatic rmw_step(input logic [13:0] w, input int cyc, input logic [7:0] wr, input logic [7:0] fd,
                            input int sk);
        int s0;
        s0 = skip_seen;
        run_word(w, 1'b0, 1'b0, cyc);
        check("wreg", o_wreg, wr);
        check("file_data", o_file_wdata, fd);
        check("skips", skip_seen - s0, sk);
    endtask
    task automatic t_rmw;
        rmw_step(14'h0185, 1, 8'h00, 8'h00, 0);
        rmw_step(14'h3055, 1, 8'h55, 8'h00, 0);
        rmw_step(14'h0085, 1, 8'h55, 8'h55, 0);
        rmw_step(14'h0a85, 1, 8'h55, 8'h56, 0);
        rmw_step(14'h0805, 1, 8'h56, 8'h56, 0);
        rmw_step(14'h0b85, 2, 8'h56, 8'h55, 0);
        rmw_step(14'h0185, 1, 8'h56, 8'h00, 0);
        rmw_step(14'h1c85, 2, 8'h56, 8'h00, 0);
        rmw_step(14'h1885, 2, 8'h56, 8'h00, 1);
        rmw_step(14'h0b85, 2, 8'h56, 8'hff, 0);
        rmw_step(14'h0f85, 2, 8'h56, 8'h00, 1);
    endtask
    task automatic t_plain;
        run_word(14'h0785, 1'b0, 1'b0, 1);
        run_word(14'h0705, 1'b0, 1'b0, 1);
    endtask
    task automatic t_call_jump;
        run_word(14'h2155, 1'b0, 1'b0, 2);
        run_word(14'h2aaa, 1'b0, 1'b0, 2);
    endtask
    task automatic t_return;
        run_word(14'h0008, 1'b0, 1'b0, 2);
    endtask
    task automatic t_count_skip;
        run_word(14'h0b85, 1'b0, 1'b0, 2);
        run_word(14'h0f05, 1'b0, 1'b0, 2);
    endtask
    // pointer in program memory only costs a cycle on its own port
    task automatic t_indirect;
        run_word(14'h0780, 1'b1, 1'b0, 2);
        run_word(14'h0780, 1'b0, 1'b1, 1);
        run_word(14'h0781, 1'b0, 1'b1, 2);
        run_word(14'h0785, 1'b1, 1'b1, 1);
    endtask
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        t_rmw();
        t_plain();
        t_call_jump();
        t_return();
        t_count_skip();
        t_indirect();
        final_report();
    end
endmodule // tb
`default_nettype wire
